// *** src/rxmst_pkg.sv ***
// Purpose: Shared constants, layouts and types for the receive message store.
// Assumes: One clock hclk at 250 MHz, one receive word per cycle at most.
// Notes: Register offsets are byte addresses on the AHB-Lite slave.
`default_nettype none
package rxmst_pkg;
    localparam int NUM_CH = 16;
    localparam int CH_W = 4;
    localparam int IND_DEPTH = 2048;
    localparam int IND_AW = 11;
    localparam int IND_CW = 12;
    localparam int MRG_DEPTH = 16384;
    localparam int MRG_AW = 14;
    localparam int MRG_CW = 15;
    localparam int KEY_W = 10;
    localparam int SNAP_BITS = NUM_CH * (1 << KEY_W);
    localparam int INTQ_AW = 11;
    localparam int INTQ_DEPTH = 2048;
    localparam int FA_W = CH_W + IND_AW;
    localparam int TAG_W = 64;
    localparam int LABEL_W = 8;
    localparam int SDI_LSB = 8;
    localparam int SDI_W = 2;
    // Timer prescale from the clock period
    localparam int CLK_PERIOD_NS = 4;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 8;
    // Queue entry values
    localparam logic [31:0] HOST_EVENT_VALUE = 32'h000000ff;
    localparam logic [31:0] FILTER_EVENT_BASE = 32'h00000040;
    // Register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFF_TIMER_LO = 8'h0c;
    localparam logic [7:0] OFF_TIMER_HI = 8'h10;
    localparam logic [7:0] OFF_IRIG_LO = 8'h14;
    localparam logic [7:0] OFF_IRIG_HI = 8'h18;
    localparam logic [7:0] OFF_MERGE_EN = 8'h1c;
    localparam logic [7:0] OFF_SNAP_KEY = 8'h20;
    localparam logic [7:0] OFF_INTQ = 8'h24;
    localparam logic [7:0] OFF_BUF_SEL = 8'h28;
    localparam logic [7:0] OFF_BUF_WORD = 8'h2c;
    localparam logic [7:0] OFF_BUF_TAG_LO = 8'h30;
    localparam logic [7:0] OFF_BUF_TAG_HI = 8'h34;
    localparam logic [7:0] OFF_BUF_INFO = 8'h38;
    localparam int CTRL_GIE_BIT = 0;
    // Sticky status bits
    localparam int ST_W = 4;
    localparam int ST_FILT = 0;
    localparam int ST_HOST = 1;
    localparam int ST_IND_OVF = 2;
    localparam int ST_MRG_OVF = 3;
    typedef enum logic [1:0] {KIND_IND = 2'b00, KIND_MRG = 2'b01, KIND_SNAP = 2'b10, KIND_INTQ = 2'b11}
        rxmst_kind_type;
    typedef enum logic [1:0] {F_IDLE = 2'b00, F_READ = 2'b01, F_LOAD = 2'b10} rxmst_fstate_type;
    typedef struct packed {
        logic valid;
        logic [CH_W-1:0] chan;
        logic [31:0] word;
        logic drop_circ;
        logic drop_snap;
        logic int_match;
    } rxmst_rx_type;
    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic [TAG_W-1:0] tag;
        logic [31:0] word;
    } rxmst_entry_type;
    typedef struct packed {
        logic [1:0] kind;
        logic [9:0] rsvd_hi;
        logic [CH_W-1:0] chan;
        logic [1:0] rsvd_lo;
        logic [13:0] index;
    } rxmst_sel_type;
    typedef struct packed {
        logic valid;
        logic [10:0] rsvd;
        logic [CH_W-1:0] chan;
        logic [15:0] count;
    } rxmst_info_type;
endpackage
`default_nettype wire

// *** src/rxmst_top.sv ***
// Purpose: Time-tagged receive message store with circular, merged and snapshot buffers and event queue.
// Assumes: Receivers are serialised upstream to one word per cycle; label filter decision arrives with it.
// Notes: Host reads buffers by writing a selector, then reading the fetched word, tag and info.
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`default_nettype none
module rxmst_top
    import rxmst_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Receive word stream and IRIG decoder
    input wire rxmst_rx_type rx,
    input wire logic irig_decoded,
    // Interrupt
    output logic irq
);
    logic dp_write;
    logic [ADDR_W-1:0] dp_addr;
    logic [31:0] rd_mux;
    logic wr_en;
    logic gie;
    logic [ST_W-1:0] irq_status;
    logic [ST_W-1:0] irq_mask;
    logic [ST_W-1:0] st_set;
    logic [PRE_W-1:0] pre;
    logic [TAG_W-1:0] timer;
    logic [31:0] timer_stage;
    logic [TAG_W-1:0] irig_ref;
    logic [NUM_CH-1:0] merge_en;
    logic [NUM_CH-1:0] snap_key_sel;
    logic [INTQ_AW-1:0] head;
    logic host_pend;
    logic host_event_insert_request;
    logic filt_evt;
    logic q_we;
    logic [31:0] q_val;
    logic [INTQ_AW-1:0] q_addr;
    logic [31:0] intq_mem [INTQ_DEPTH];
    logic [31:0] intq_q;
    rxmst_entry_type new_entry;
    rxmst_entry_type snap_entry;
    logic push_ind;
    logic push_mrg;
    logic push_snap;
    logic [KEY_W-1:0] snap_key;
    logic [IND_AW-1:0] ind_wr [NUM_CH];
    logic [IND_AW-1:0] ind_rd [NUM_CH];
    logic [IND_CW-1:0] ind_cnt [NUM_CH];
    logic [NUM_CH-1:0] ind_ovf;
    rxmst_entry_type ind_mem [NUM_CH*IND_DEPTH];
    rxmst_entry_type ind_q;
    logic [MRG_AW-1:0] mrg_wr;
    logic [MRG_AW-1:0] mrg_rd;
    logic [MRG_CW-1:0] mrg_cnt;
    logic mrg_ovf;
    logic pop_mrg;
    rxmst_entry_type mrg_mem [MRG_DEPTH];
    rxmst_entry_type mrg_q;
    rxmst_entry_type snap_mem [SNAP_BITS];
    rxmst_entry_type snap_q;
    logic [SNAP_BITS-1:0] snap_vld;
    rxmst_sel_type sel;
    logic sel_wr;
    rxmst_fstate_type fstate;
    rxmst_kind_type f_kind;
    logic [FA_W-1:0] f_addr;
    logic f_valid;
    logic [15:0] f_count;
    logic [31:0] buf_word;
    logic [TAG_W-1:0] buf_tag;
    rxmst_info_type buf_info;
    rxmst_entry_type f_entry;

    // Bus handshake; fetch cycles stall the next address phase
    assign hreadyout = (fstate == F_IDLE);
    assign hresp = 1'b0;
    assign wr_en = dp_write;
    assign sel = rxmst_sel_type'(hwdata);
    assign sel_wr = wr_en && (dp_addr == OFF_BUF_SEL);

    // Address phase capture and registered read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= '0;
            hrdata <= '0;
        end else begin
            dp_write <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready) begin
                dp_addr <= haddr[ADDR_W-1:0];
                if (!hwrite) begin
                    hrdata <= rd_mux;
                end
            end
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        case (haddr[ADDR_W-1:0])
            OFF_CTRL: rd_mux = 32'(gie);
            OFF_IRQ_STATUS: rd_mux = 32'(irq_status);
            OFF_IRQ_MASK: rd_mux = 32'(irq_mask);
            OFF_TIMER_LO: rd_mux = timer[31:0];
            OFF_TIMER_HI: rd_mux = timer[TAG_W-1:32];
            OFF_IRIG_LO: rd_mux = irig_ref[31:0];
            OFF_IRIG_HI: rd_mux = irig_ref[TAG_W-1:32];
            OFF_MERGE_EN: rd_mux = 32'(merge_en);
            OFF_SNAP_KEY: rd_mux = 32'(snap_key_sel);
            OFF_INTQ: rd_mux = 32'(head);
            OFF_BUF_WORD: rd_mux = buf_word;
            OFF_BUF_TAG_LO: rd_mux = buf_tag[31:0];
            OFF_BUF_TAG_HI: rd_mux = buf_tag[TAG_W-1:32];
            OFF_BUF_INFO: rd_mux = buf_info;
            default: rd_mux = '0;
        endcase
    end

    // Plain control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gie <= 1'b0;
            irq_mask <= '0;
            merge_en <= '0;
            snap_key_sel <= '0;
            timer_stage <= '0;
        end else if (wr_en) begin
            case (dp_addr)
                OFF_CTRL: gie <= hwdata[CTRL_GIE_BIT];
                OFF_IRQ_MASK: irq_mask <= hwdata[ST_W-1:0];
                OFF_MERGE_EN: merge_en <= hwdata[NUM_CH-1:0];
                OFF_SNAP_KEY: snap_key_sel <= hwdata[NUM_CH-1:0];
                OFF_TIMER_LO: timer_stage <= hwdata;
                default: ;
            endcase
        end
    end

    // Microsecond timer; a high-word write loads all 64 bits at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre <= '0;
            timer <= '0;
        end else if (wr_en && dp_addr == OFF_TIMER_HI) begin
            pre <= '0;
            timer <= {hwdata, timer_stage};
        end else if (pre == PRE_W'(CYC_PER_US - 1)) begin
            pre <= '0;
            timer <= timer + 64'h1;
        end else begin
            pre <= pre + 8'h01;
        end
    end

    // IRIG reference time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irig_ref <= '0;
        end else if (irig_decoded) begin
            irig_ref <= timer;
        end
    end

    // Sticky status, set wins over write-one-to-clear
    assign st_set = {mrg_ovf, |ind_ovf, host_event_insert_request && !filt_evt, filt_evt};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
        end else if (wr_en && dp_addr == OFF_IRQ_STATUS) begin
            irq_status <= (irq_status & ~hwdata[ST_W-1:0]) | st_set;
        end else begin
            irq_status <= irq_status | st_set;
        end
    end
    assign irq = gie && |(irq_status & irq_mask);

    // Event queue; a host insert colliding with a filter event waits for the next slot without one
    assign filt_evt = rx.valid && rx.int_match;
    assign host_event_insert_request = (wr_en && dp_addr == OFF_INTQ) || host_pend;
    assign q_we = filt_evt || host_event_insert_request;
    assign q_val = filt_evt ? FILTER_EVENT_BASE + 32'(rx.chan) : HOST_EVENT_VALUE;
    assign q_addr = head + 11'h001;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            head <= INTQ_AW'(INTQ_DEPTH - 1);
            host_pend <= 1'b0;
        end else begin
            host_pend <= host_event_insert_request && filt_evt;
            if (q_we) begin
                head <= q_addr;
            end
        end
    end
    always_ff @(posedge hclk) begin
        if (q_we) begin
            intq_mem[q_addr] <= q_val;
        end
        intq_q <= intq_mem[f_addr[INTQ_AW-1:0]];
    end

    // Message routing and time-tag capture at the word's last bit
    assign new_entry = '{chan: rx.chan, tag: timer, word: rx.word};
    assign push_ind = rx.valid && !rx.drop_circ && !merge_en[rx.chan];
    assign push_mrg = rx.valid && !rx.drop_circ && merge_en[rx.chan];
    assign push_snap = rx.valid && !rx.drop_snap;
    assign snap_key = snap_key_sel[rx.chan] ? {rx.word[SDI_LSB+SDI_W-1:SDI_LSB], rx.word[LABEL_W-1:0]}
        : KEY_W'(rx.word[LABEL_W-1:0]);
    assign snap_entry = '{chan: rx.chan, tag: snap_key_sel[rx.chan] ? '0 : timer, word: rx.word};

    // Per-channel circular buffer pointers
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ind
        logic push_c;
        logic pop_c;
        logic full_c;
        assign push_c = push_ind && (rx.chan == CH_W'(ch));
        assign full_c = (ind_cnt[ch] == IND_CW'(IND_DEPTH));
        assign pop_c = sel_wr && (sel.kind == KIND_IND) && (sel.chan == CH_W'(ch)) && (ind_cnt[ch] != '0);
        assign ind_ovf[ch] = push_c && full_c;
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ind_wr[ch] <= '0;
                ind_rd[ch] <= '0;
                ind_cnt[ch] <= '0;
            end else if (push_c && full_c) begin
                // Overflow discards everything older than the new word
                ind_rd[ch] <= ind_wr[ch];
                ind_wr[ch] <= ind_wr[ch] + 11'h001;
                ind_cnt[ch] <= 12'h001;
            end else begin
                ind_wr[ch] <= ind_wr[ch] + IND_AW'(push_c);
                ind_rd[ch] <= ind_rd[ch] + IND_AW'(pop_c);
                ind_cnt[ch] <= ind_cnt[ch] + IND_CW'(push_c) - IND_CW'(pop_c);
            end
        end
        property p_ovf;
            @(posedge hclk) disable iff (!hresetn) (push_c && full_c) |=> (ind_cnt[ch] == 12'h001);
        endproperty
        a_ovf: assert property (p_ovf) else $error("overflow did not leave one message");
    end

    // Individual buffer storage
    always_ff @(posedge hclk) begin
        if (push_ind) begin
            ind_mem[{rx.chan, ind_wr[rx.chan]}] <= new_entry;
        end
        ind_q <= ind_mem[f_addr];
    end

    // Merged buffer; single arrival port keeps reception order
    assign pop_mrg = sel_wr && (sel.kind == KIND_MRG) && (mrg_cnt != '0);
    assign mrg_ovf = push_mrg && (mrg_cnt == MRG_CW'(MRG_DEPTH));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mrg_wr <= '0;
            mrg_rd <= '0;
            mrg_cnt <= '0;
        end else if (mrg_ovf) begin
            mrg_rd <= mrg_wr;
            mrg_wr <= mrg_wr + 14'h0001;
            mrg_cnt <= 15'h0001;
        end else begin
            mrg_wr <= mrg_wr + MRG_AW'(push_mrg);
            mrg_rd <= mrg_rd + MRG_AW'(pop_mrg);
            mrg_cnt <= mrg_cnt + MRG_CW'(push_mrg) - MRG_CW'(pop_mrg);
        end
    end
    always_ff @(posedge hclk) begin
        if (push_mrg) begin
            mrg_mem[mrg_wr] <= new_entry;
        end
        mrg_q <= mrg_mem[f_addr[MRG_AW-1:0]];
    end

    // Snapshot table; validity bits make unseen keys read zero
    always_ff @(posedge hclk) begin
        if (push_snap) begin
            snap_mem[{rx.chan, snap_key}] <= snap_entry;
        end
        snap_q <= snap_mem[f_addr[CH_W+KEY_W-1:0]];
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            snap_vld <= '0;
        end else if (push_snap) begin
            snap_vld[{rx.chan, snap_key}] <= 1'b1;
        end
    end

    // Host fetch: selector write, memory read, then load of result registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fstate <= F_IDLE;
            f_kind <= KIND_IND;
            f_addr <= '0;
            f_valid <= 1'b0;
            f_count <= '0;
        end else begin
            case (fstate)
                F_IDLE: begin
                    if (sel_wr) begin
                        fstate <= F_READ;
                        f_kind <= rxmst_kind_type'(sel.kind);
                        f_count <= '0;
                        case (rxmst_kind_type'(sel.kind))
                            KIND_IND: begin
                                f_addr <= {sel.chan, ind_rd[sel.chan]};
                                f_valid <= (ind_cnt[sel.chan] != '0);
                                f_count <= 16'(ind_cnt[sel.chan]);
                            end
                            KIND_MRG: begin
                                f_addr <= FA_W'(mrg_rd);
                                f_valid <= (mrg_cnt != '0);
                                f_count <= 16'(mrg_cnt);
                            end
                            KIND_SNAP: begin
                                f_addr <= FA_W'({sel.chan, sel.index[KEY_W-1:0]});
                                f_valid <= snap_vld[{sel.chan, sel.index[KEY_W-1:0]}];
                            end
                            default: begin
                                f_addr <= FA_W'(sel.index[INTQ_AW-1:0]);
                                f_valid <= 1'b1;
                            end
                        endcase
                    end
                end
                F_READ: fstate <= F_LOAD;
                F_LOAD: fstate <= F_IDLE;
                default: fstate <= F_IDLE;
            endcase
        end
    end

    // Result selection from the memory read registers
    always_comb begin
        case (f_kind)
            KIND_IND: f_entry = ind_q;
            KIND_MRG: f_entry = mrg_q;
            KIND_SNAP: f_entry = snap_q;
            default: f_entry = '{chan: '0, tag: '0, word: intq_q};
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_word <= '0;
            buf_tag <= '0;
            buf_info <= '0;
        end else if (fstate == F_LOAD) begin
            buf_word <= f_valid ? f_entry.word : '0;
            buf_tag <= f_valid ? f_entry.tag : '0;
            buf_info <= '{valid: f_valid, rsvd: '0, chan: f_valid ? f_entry.chan : '0, count: f_count};
        end
    end

    // Checks
    property p_load;
        @(posedge hclk) disable iff (!hresetn)
            (wr_en && dp_addr == OFF_TIMER_HI) |=> (timer == {$past(hwdata), $past(timer_stage)});
    endproperty
    a_load: assert property (p_load) else $error("timer not loaded from host value");
    property p_tick;
        @(posedge hclk) disable iff (!hresetn)
            (timer == $past(timer) + 64'h1) && !$past(wr_en && dp_addr == OFF_TIMER_HI)
            |-> ($past(pre) == PRE_W'(CYC_PER_US - 1));
    endproperty
    a_tick: assert property (p_tick) else $error("timer advanced off the microsecond");
    property p_irig;
        @(posedge hclk) disable iff (!hresetn) irig_decoded |=> (irig_ref == $past(timer));
    endproperty
    a_irig: assert property (p_irig) else $error("irig reference not latched");
    property p_view;
        @(posedge hclk) disable iff (!hresetn)
            (hsel && htrans[1] && hready && !hwrite && haddr[ADDR_W-1:0] == OFF_TIMER_LO)
            |=> (hrdata == $past(timer[31:0]));
    endproperty
    a_view: assert property (p_view) else $error("32-bit view differs from tag low word");
    property p_host_q;
        @(posedge hclk) disable iff (!hresetn)
            (host_event_insert_request && !filt_evt)
            |=> (head == $past(head) + 11'h001) && (intq_mem[head] == HOST_EVENT_VALUE);
    endproperty
    a_host_q: assert property (p_host_q) else $error("host insert not queued");
    property p_filt_q;
        @(posedge hclk) disable iff (!hresetn)
            filt_evt |=> (intq_mem[head] == FILTER_EVENT_BASE + 32'($past(rx.chan)));
    endproperty
    a_filt_q: assert property (p_filt_q) else $error("filter event value wrong");
    property p_wrap;
        @(posedge hclk) disable iff (!hresetn)
            (q_we && head == INTQ_AW'(INTQ_DEPTH - 1)) |=> (head == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("queue head did not wrap");
    property p_pend;
        @(posedge hclk) disable iff (!hresetn)
            (host_event_insert_request && filt_evt) |=> host_event_insert_request ##0 q_we;
    endproperty
    a_pend: assert property (p_pend) else $error("colliding host insert lost");
    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
            (filt_evt && gie && irq_mask[ST_FILT] && !wr_en) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled event gave no interrupt");
    property p_merge;
        @(posedge hclk) disable iff (!hresetn)
            (push_mrg && !pop_mrg && !mrg_ovf) |=> (mrg_cnt == $past(mrg_cnt) + 15'h0001) && $stable(ind_wr[0]);
    endproperty
    a_merge: assert property (p_merge) else $error("merged push miscounted");
    property p_snap_zero;
        @(posedge hclk) disable iff (!hresetn)
            (fstate == F_LOAD && !f_valid) |=> (buf_word == '0) && (buf_tag == '0);
    endproperty
    a_snap_zero: assert property (p_snap_zero) else $error("unseen entry not zero");
    c_ovf: cover property (@(posedge hclk) disable iff (!hresetn) mrg_ovf || |ind_ovf);
    c_host: cover property (@(posedge hclk) disable iff (!hresetn) host_event_insert_request ##1 irq);
    c_snap: cover property (@(posedge hclk) disable iff (!hresetn) fstate == F_LOAD && f_kind == KIND_SNAP && f_valid);
    c_pend: cover property (@(posedge hclk) disable iff (!hresetn) host_pend);
endmodule
`default_nettype wire

// *** tb/rxmst_rx_model.sv ***
// Purpose: Receiver model that hands one finished word to the store.
// Assumes: One word per request; the valid pulse lasts one clock.
// Notes: Idle word lines invert on every clock after the last word, so no stale copy can pass.
`default_nettype none
module rxmst_rx_model
    import rxmst_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Request from the bench
    input wire logic send,
    input wire logic [CH_W-1:0] chan,
    input wire logic [31:0] word,
    input wire logic int_match,
    // Word stream to the store
    output rxmst_rx_type rx
);
    timeunit 1ns;
    timeprecision 1ps;
    // Last bit seen: one valid cycle, then the word lines are scrambled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx <= '0;
        end else if (send) begin
            rx <= '{valid: 1'b1, chan: chan, word: word, drop_circ: 1'b0, drop_snap: 1'b0, int_match: int_match};
        end else begin
            rx.valid <= 1'b0;
            rx.word <= ~rx.word;
            rx.int_match <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** tb/rxmst_tb_top.sv ***
// Purpose: Self-checking bench for the receive message store.
// Assumes: One AHB-Lite master, hready looped from hreadyout.
// Notes: Timer reads stay well inside one 250-cycle tick after the load.
`default_nettype none
module rxmst_tb_top
    import rxmst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, irig = 1'b0, send = 1'b0, intm = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, wd = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata, rd, a, b;
    logic [CH_W-1:0] ch = '0;
    rxmst_rx_type rx;
    int n_errors = 0;
    int samples_checked = 0;
    integer seed = 32'hf1cb09e4;
    // Free-running 250 MHz clock
    always #2 hclk = ~hclk;
    rxmst_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx(rx), .irig_decoded(irig), .irq(irq));
    rxmst_rx_model rxm_u (.hclk(hclk), .hresetn(hresetn), .send(send), .chan(ch), .word(wd), .int_match(intm),
        .rx(rx));
    task automatic end_sim();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits for hready high at a rising edge, grabbing read data just before it
    task automatic hwait(output logic [31:0] r);
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        r = hrdata;
        @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, adr};
        hwait(r);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        hwait(r);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        bus(1'b1, adr, d, rd);
    endtask
    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0, rd);
        chk(rd, exp);
    endtask
    task automatic sel(input logic [1:0] k, input logic [13:0] idx);
        wr(OFF_BUF_SEL, {k, 10'h0, ch, 2'b00, idx});
    endtask
    task automatic sendw(input logic m);
        wd <= $random(seed);
        intm <= m;
        send <= 1'b1;
        @(posedge hclk);
        send <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    // Main sequence; random channel, word and timer value, fixed corner order
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(OFF_INTQ, 32'h7ff);
        rchk(8'h3c, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        a = $random(seed) & 32'h7fffffff;
        b = $random(seed);
        ch <= CH_W'($random(seed));
        wr(OFF_TIMER_LO, a);
        wr(OFF_TIMER_HI, b);
        irig <= 1'b1;
        @(posedge hclk);
        irig <= 1'b0;
        rchk(OFF_IRIG_LO, a);
        rchk(OFF_IRIG_HI, b);
        rchk(OFF_TIMER_HI, b);
        wr(OFF_INTQ, 32'h0);
        rchk(OFF_INTQ, 32'h0);
        sendw(1'b1);
        sel(KIND_IND, 14'h0);
        rchk(OFF_BUF_WORD, wd);
        rchk(OFF_BUF_TAG_LO, a);
        rchk(OFF_BUF_TAG_HI, b);
        sel(KIND_SNAP, {6'h0, wd[7:0]});
        rchk(OFF_BUF_WORD, wd);
        rchk(OFF_BUF_TAG_HI, b);
        sel(KIND_SNAP, {6'h0, ~wd[7:0]});
        rchk(OFF_BUF_WORD, 32'h0);
        sel(KIND_INTQ, 14'h0);
        rchk(OFF_BUF_WORD, HOST_EVENT_VALUE);
        sel(KIND_INTQ, 14'h1);
        rchk(OFF_BUF_WORD, FILTER_EVENT_BASE + {28'h0, ch});
        wr(OFF_MERGE_EN, 32'h1 << ch);
        sendw(1'b0);
        sel(KIND_IND, 14'h0);
        rchk(OFF_BUF_WORD, 32'h0);
        sel(KIND_MRG, 14'h0);
        rchk(OFF_BUF_WORD, wd);
        wr(OFF_IRQ_MASK, 32'h2);
        wr(OFF_CTRL, 32'h1);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        @(posedge hclk);
        wr(OFF_IRQ_STATUS, 32'hf);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        @(posedge hclk);
        // Filter event with the interrupt already enabled
        wr(OFF_IRQ_MASK, 32'h1);
        sendw(1'b1);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        @(posedge hclk);
        // Label plus SDI keying keeps no time-tag
        wr(OFF_SNAP_KEY, 32'h1 << ch);
        sendw(1'b0);
        sel(KIND_SNAP, {4'h0, wd[9:0]});
        rchk(OFF_BUF_WORD, wd);
        rchk(OFF_BUF_TAG_HI, 32'h0);
        // One word past a full buffer leaves only that word
        wr(OFF_MERGE_EN, 32'h0);
        repeat (IND_DEPTH + 1) sendw(1'b0);
        sel(KIND_IND, 14'h0);
        rchk(OFF_BUF_INFO, {1'b1, 11'h0, ch, 16'h0001});
        rchk(OFF_BUF_WORD, wd);
        rchk(OFF_IRQ_STATUS, 32'h5);
        end_sim();
    end
    // Watchdog: the overflow fill makes the sequence a little over six thousand cycles
    initial begin
        #60000;
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
